// >>> lbm_ctrl_model.sv
// Frame-bus controller model: frame sync pin and command channel code.
// Assumes the bench chooses the next command; frame sync runs free.
`timescale 1ns/10ps
`include "lbm_params.svh"

module lbm_ctrl_model (
  // Command chosen by the bench
  input  wire logic [`LBM_CI_W-1:0] i_next_cmd,
  // Pins toward the block
  output logic                      o_frame_sync,
  output logic      [`LBM_CI_W-1:0] o_ci_cmd
);
  // ==========================================================
  // Frame clock, 160 ns, phase unrelated to the reference clock
  initial begin
    o_frame_sync = 1'b0;
    o_ci_cmd     = `LBM_CI_TIM;
    #7;
    forever begin
      #80 o_frame_sync = ~o_frame_sync;
      // Code changes mid-frame, so it is long stable at the sampling edge
      if (!o_frame_sync) begin
        o_ci_cmd = i_next_cmd;
      end
    end
  end
endmodule

// >>> lbm_loop_maint.sv
// Layer-1 maintenance control: complete and single-channel loop-backs,
// code-violation monitor and command-channel reset/timing handling.
// Assumes the frame sync and command channel arrive from pins; the layer-1
// state, indication and code-violation pulse come from logic on i_ref_clk.
//
// Notes on behaviour
// - Strap high makes the device come out of reset in LT-S mode.
// - In TE and LT-T the analog loop command closes the loop in any state.
// - In NT and LT-S it works only in deactivation states; NT also in I0.
// - Complete-loop bit closes the loop only in LT-S or NT while activated.
// - Complete loop is closed internally next to the line interface.
// - Transparency bit chooses whether looped data also goes out on the line.
// - Each single-channel loop closes by writing one to its own bit.
// - Bus-side loops return B data received from the line back to the line.
// - Bus-side B1 and B2 loop bits act independently, both together loop both.
// - Channel swap exchanges B1 and B2 only while both bus-side bits are set.
// - Line-side B loop bits act only in LT-S or NT mode.
// - Single-channel loops close only in the fully activated state.
// - A code violation gives the violation indication for six frames.
// - Violation reporting ignores multiframing entirely.
// - Violation reporting runs only while its enable bit is one.
// - Reset command resets the state machine, sends idle, ignores the line.
// - Timing command requests frame-bus clocks and leaves the reset state.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "lbm_params.svh"

module lbm_loop_maint
  import lbm_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_reset_n,
  // Pins from outside
  input  wire logic                  i_mode_strap,
  input  wire logic                  i_frame_sync,
  input  wire logic [`LBM_CI_W-1:0]  i_ci_cmd,
  // Layer-1 core, same clock
  input  wire logic [`LBM_ST_W-1:0]  i_l1_state,
  input  wire logic [`LBM_CI_W-1:0]  i_l1_ind,
  input  wire logic                  i_line_cv,
  // B-channel data paths
  input  wire logic [`LBM_DATA_W-1:0] i_line_b1,
  input  wire logic [`LBM_DATA_W-1:0] i_line_b2,
  input  wire logic [`LBM_DATA_W-1:0] i_bus_b1,
  input  wire logic [`LBM_DATA_W-1:0] i_bus_b2,
  output logic      [`LBM_DATA_W-1:0] o_line_b1,
  output logic      [`LBM_DATA_W-1:0] o_line_b2,
  output logic      [`LBM_DATA_W-1:0] o_bus_b1,
  output logic      [`LBM_DATA_W-1:0] o_bus_b2,
  // Register port
  input  wire logic [`LBM_ADDR_W-1:0] i_reg_addr,
  input  wire logic [`LBM_DATA_W-1:0] i_reg_wdata,
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  output logic      [`LBM_DATA_W-1:0] o_reg_rdata,
  // Status and control outputs
  output logic                        o_analog_loop,
  output logic                        o_line_tx_mute,
  output logic      [`LBM_CI_W-1:0]   o_ci_ind,
  output logic                        o_sm_reset,
  output logic                        o_force_idle,
  output logic                        o_ignore_rx,
  output logic                        o_clk_request,
  output logic      [1:0]             o_mode
);

  // ==========================================================
  // Pin synchronisers; first stages feed only the second stages
  logic                 strap_s1_r, strap_s2_r;
  logic                 fs_s1_r, fs_s2_r, fs_d_r;
  logic [`LBM_CI_W-1:0] ci_s1_r, ci_s2_r;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      strap_s1_r <= 1'b0;
      strap_s2_r <= 1'b0;
      fs_s1_r    <= 1'b0;
      fs_s2_r    <= 1'b0;
      fs_d_r     <= 1'b0;
      ci_s1_r    <= '0;
      ci_s2_r    <= '0;
    end else begin
      strap_s1_r <= i_mode_strap;
      strap_s2_r <= strap_s1_r;
      fs_s1_r    <= i_frame_sync;
      fs_s2_r    <= fs_s1_r;
      fs_d_r     <= fs_s2_r;
      ci_s1_r    <= i_ci_cmd;
      ci_s2_r    <= ci_s1_r;
    end
  end

  // Frame boundary: rising edge of the synchronised frame sync
  logic frame_tick;
  assign frame_tick = fs_s2_r & ~fs_d_r;

  // ==========================================================
  // Strap capture after reset release
  logic [1:0] strap_cnt_r;
  logic       strap_done;
  assign strap_done = (strap_cnt_r == `LBM_STRAP_WAIT);

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      strap_cnt_r <= '0;
    end else if (!strap_done) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
    end
  end

  // ==========================================================
  // Register file
  logic [`LBM_DATA_W-1:0] cfg_r;
  logic [`LBM_DATA_W-1:0] loop_r;
  lbm_mode_e              mode;
  logic                   wr_cfg, wr_loop;

  assign wr_cfg  = i_reg_wr && (i_reg_addr == `LBM_OFS_CFG);
  assign wr_loop = i_reg_wr && (i_reg_addr == `LBM_OFS_LOOP);
  assign mode    = lbm_mode_e'(cfg_r[`LBM_CFG_MODE_HI:`LBM_CFG_MODE_LO]);

  // Strap is only taken once the synchroniser is full; a write in that same cycle wins over it
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_r <= `LBM_CFG_RST;
    end else if (wr_cfg) begin
      cfg_r <= i_reg_wdata;
    end else if ((strap_cnt_r == `LBM_STRAP_WAIT - 2'h1) && strap_s2_r) begin
      cfg_r[`LBM_CFG_MODE_HI:`LBM_CFG_MODE_LO] <= LBM_MODE_LTS;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      loop_r <= `LBM_LP_RST;
    end else if (wr_loop) begin
      loop_r <= i_reg_wdata;
    end
  end

  // ==========================================================
  // Decode helpers
  function automatic logic is_nt_lts(input lbm_mode_e m);
    is_nt_lts = (m == LBM_MODE_NT) || (m == LBM_MODE_LTS);
  endfunction

  function automatic logic arl_allowed(input lbm_mode_e m, input logic [`LBM_ST_W-1:0] st);
    if (!is_nt_lts(m)) begin
      arl_allowed = 1'b1;
    end else begin
      arl_allowed = (st == `LBM_ST_PEND_DEACT) || (st == `LBM_ST_WAIT_DR) ||
                    (st == `LBM_ST_DEACT) ||
                    ((m == LBM_MODE_NT) && (st == `LBM_ST_I0_DET));
    end
  endfunction

  logic activated;
  assign activated = (i_l1_state == `LBM_ST_ACTIVATED);

  // ==========================================================
  // Command channel: reset, timing and analog loop request
  logic arl_r, l1_reset_r, clk_req_r, sm_reset_r;

  // Analog loop is re-judged every frame; a missing command opens it
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      arl_r <= 1'b0;
    end else if (frame_tick) begin
      arl_r <= (ci_s2_r == `LBM_CI_ARL) && arl_allowed(mode, i_l1_state);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      l1_reset_r <= 1'b0;
      clk_req_r  <= 1'b0;
      sm_reset_r <= 1'b0;
    end else begin
      sm_reset_r <= frame_tick && (ci_s2_r == `LBM_CI_RES);
      if (frame_tick && (ci_s2_r == `LBM_CI_RES)) begin
        l1_reset_r <= 1'b1;
        clk_req_r  <= 1'b0;
      end else if (frame_tick && (ci_s2_r == `LBM_CI_TIM)) begin
        l1_reset_r <= 1'b0;
        clk_req_r  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Complete loop-back, closed inside next to the line port
  logic sc_loop, cmpl_loop;
  assign sc_loop   = loop_r[`LBM_LP_SC] && is_nt_lts(mode) && activated;
  assign cmpl_loop = arl_r || sc_loop;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_analog_loop  <= 1'b0;
      o_line_tx_mute <= 1'b0;
    end else begin
      o_analog_loop  <= cmpl_loop;
      o_line_tx_mute <= cmpl_loop && !cfg_r[`LBM_CFG_LPTR];
    end
  end

  // ==========================================================
  // Single-channel loop-backs
  logic bl1, bl2, swap, sl1, sl2;
  assign bl1  = loop_r[`LBM_LP_IB1] && activated;
  assign bl2  = loop_r[`LBM_LP_IB2] && activated;
  assign swap = loop_r[`LBM_LP_SWAP] && bl1 && bl2;
  assign sl1  = loop_r[`LBM_LP_SB1] && is_nt_lts(mode) && activated;
  assign sl2  = loop_r[`LBM_LP_SB2] && is_nt_lts(mode) && activated;

  // Looped bytes still flow onward in the normal direction unless that channel is looped on both sides
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_line_b1 <= '0;
      o_line_b2 <= '0;
      o_bus_b1  <= '0;
      o_bus_b2  <= '0;
    end else begin
      o_line_b1 <= bl1 ? (swap ? i_line_b2 : i_line_b1) : i_bus_b1;
      o_line_b2 <= bl2 ? (swap ? i_line_b1 : i_line_b2) : i_bus_b2;
      o_bus_b1  <= sl1 ? i_bus_b1 : i_line_b1;
      o_bus_b2  <= sl2 ? i_bus_b2 : i_line_b2;
    end
  end

  // ==========================================================
  // Code-violation monitor, counted in bus frames only
  logic       cv_pend_r;
  logic [2:0] cv_cnt_r;
  logic       cv_en;
  assign cv_en = cfg_r[`LBM_CFG_CVEN] && !l1_reset_r;

  // A violation in the cycle the pending flag is consumed still counts
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cv_pend_r <= 1'b0;
      cv_cnt_r  <= '0;
    end else if (!cv_en) begin
      cv_pend_r <= 1'b0;
      cv_cnt_r  <= '0;
    end else begin
      if (i_line_cv) begin
        cv_pend_r <= 1'b1;
      end else if (frame_tick) begin
        cv_pend_r <= 1'b0;
      end
      if (frame_tick && cv_pend_r) begin
        cv_cnt_r <= `LBM_CV_LAST;
      end else if (frame_tick && (cv_cnt_r != 3'h0)) begin
        cv_cnt_r <= cv_cnt_r - 3'h1;
      end
    end
  end

  // Indication changes only at a frame boundary
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ci_ind <= `LBM_CI_TIM;
    end else if (frame_tick) begin
      if (cv_en && (cv_pend_r || cv_cnt_r != 3'h0)) begin
        o_ci_ind <= `LBM_CI_CVR;
      end else if (l1_reset_r) begin
        o_ci_ind <= `LBM_CI_TIM;
      end else begin
        o_ci_ind <= i_l1_ind;
      end
    end
  end

  // ==========================================================
  // Control outputs and read port
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sm_reset    <= 1'b0;
      o_force_idle  <= 1'b0;
      o_ignore_rx   <= 1'b0;
      o_clk_request <= 1'b0;
      o_mode        <= LBM_MODE_TE;
    end else begin
      o_sm_reset    <= sm_reset_r;
      o_force_idle  <= l1_reset_r;
      o_ignore_rx   <= l1_reset_r;
      o_clk_request <= clk_req_r;
      o_mode        <= mode;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= '0;
    end else if (!i_reg_rd) begin
      o_reg_rdata <= '0;
    end else begin
      case (i_reg_addr)
        `LBM_OFS_CFG:  o_reg_rdata <= cfg_r;
        `LBM_OFS_LOOP: o_reg_rdata <= loop_r;
        `LBM_OFS_STAT: o_reg_rdata <= {3'h0, clk_req_r, l1_reset_r, cv_pend_r | (cv_cnt_r != 3'h0),
                                       sc_loop, arl_r};
        default:       o_reg_rdata <= '0;
      endcase
    end
  end

  // ==========================================================
  // Checks
  // Guard: data outputs still hold reset values in the first cycle after release
  logic live_r;
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      live_r <= 1'b0;
    end else begin
      live_r <= 1'b1;
    end
  end
  sequence cv_seen_s;
    cv_en && i_line_cv && !frame_tick;
  endsequence

  sequence cv_shown_s;
    frame_tick ##1 (o_ci_ind == `LBM_CI_CVR);
  endsequence

  cv_report_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    cv_seen_s ##1 (cv_en && frame_tick) |-> ##1 (o_ci_ind == `LBM_CI_CVR))
    else $error("violation not indicated at next frame");

  cv_six_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (frame_tick && cv_en && cv_pend_r) |-> ##1 (cv_cnt_r == `LBM_CV_LAST))
    else $error("violation frame count not loaded");

  cv_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !cfg_r[`LBM_CFG_CVEN] |=> (cv_cnt_r == 3'h0) && !cv_pend_r)
    else $error("violation state kept while disabled");

  arl_drop_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (frame_tick && ci_s2_r != `LBM_CI_ARL) |=> !arl_r ##1 (o_analog_loop == $past(sc_loop)))
    else $error("analog loop held without command");

  arl_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (frame_tick && is_nt_lts(mode) && activated) |=> !arl_r)
    else $error("analog loop closed in active state");

  swap_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (live_r && !loop_r[`LBM_LP_IB2] && activated) |=> (o_line_b2 == $past(i_bus_b2)))
    else $error("line B2 altered without its loop bit");

  single_act_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (live_r && !activated) |=> (o_line_b1 == $past(i_bus_b1)) && (o_bus_b1 == $past(i_line_b1)))
    else $error("single loop closed while not activated");

  res_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (frame_tick && ci_s2_r == `LBM_CI_RES) |-> ##2 (o_force_idle && o_ignore_rx && o_sm_reset))
    else $error("reset command not applied");

  mute_sel_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    cmpl_loop |=> (o_line_tx_mute == !$past(cfg_r[`LBM_CFG_LPTR])))
    else $error("transparency selection wrong");

endmodule

// >>> lbm_params.svh
// Constants for the layer-1 loop-back and maintenance block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef LBM_PARAMS_SVH
`define LBM_PARAMS_SVH

// ==========================================================
// Register offsets (index on the plain register port)
`define LBM_ADDR_W        4
`define LBM_DATA_W        8
`define LBM_OFS_CFG       4'h0
`define LBM_OFS_LOOP      4'h1
`define LBM_OFS_STAT      4'h2

// ==========================================================
// Configuration register fields
`define LBM_CFG_MODE_LO   0
`define LBM_CFG_MODE_HI   1
`define LBM_CFG_CVEN      2
`define LBM_CFG_LPTR      3
`define LBM_CFG_RST       8'h00

// ==========================================================
// Loop-back register fields
`define LBM_LP_SC         0
`define LBM_LP_IB1        1
`define LBM_LP_IB2        2
`define LBM_LP_SWAP       3
`define LBM_LP_SB1        4
`define LBM_LP_SB2        5
`define LBM_LP_RST        8'h00

// ==========================================================
// Command / indication codes (4-bit channel)
`define LBM_CI_W          4
`define LBM_CI_RES        4'h1
`define LBM_CI_TIM        4'h0
`define LBM_CI_ARL        4'hA
`define LBM_CI_CVR        4'hB
`define LBM_CI_AI         4'hC

// ==========================================================
// Layer-1 state codes reported by the state machine
`define LBM_ST_W          4
`define LBM_ST_DEACT      4'h0
`define LBM_ST_I0_DET     4'h1
`define LBM_ST_ACTIVATED  4'h7
`define LBM_ST_PEND_DEACT 4'hC
`define LBM_ST_WAIT_DR    4'hD

// ==========================================================
// Counts
`define LBM_CV_FRAMES     3'h6
`define LBM_CV_LAST       3'h5
`define LBM_STRAP_WAIT    2'h3

`endif

// >>> lbm_pkg.sv
// Types shared by the loop-back and maintenance block.
// Assumes lbm_params.svh is on the include path.
`include "lbm_params.svh"

package lbm_pkg;

  // ==========================================================
  // Operating modes, as held in the configuration register
  typedef enum logic [1:0] {
    LBM_MODE_TE  = 2'h0,
    LBM_MODE_LTT = 2'h1,
    LBM_MODE_NT  = 2'h2,
    LBM_MODE_LTS = 2'h3
  } lbm_mode_e;

  typedef logic [`LBM_DATA_W-1:0] lbm_byte_t;

endpackage

// >>> lbm_tb.sv
// Self-checking bench for the loop-back and maintenance block.
// Assumes lbm_pkg and lbm_ctrl_model are compiled first.
`timescale 1ns/10ps
`include "lbm_params.svh"

module tb
  import lbm_pkg::*;
;
  logic        i_ref_clk, i_reset_n, i_mode_strap, i_line_cv, i_reg_wr, i_reg_rd, seen_rst;
  logic [3:0]  i_l1_state, i_l1_ind, i_reg_addr, next_cmd, o_ci_ind;
  logic [7:0]  i_line_b1, i_line_b2, i_bus_b1, i_bus_b2, i_reg_wdata, o_reg_rdata;
  logic [7:0]  o_line_b1, o_line_b2, o_bus_b1, o_bus_b2;
  logic        o_analog_loop, o_line_tx_mute, o_sm_reset, o_force_idle, o_ignore_rx, o_clk_request;
  logic [1:0]  o_mode;
  wire logic   i_frame_sync;
  wire logic [3:0] i_ci_cmd;
  int          err_count, cmp_count, cycles, k;
  // Cfg, state, expected loop
  logic [15:0] arl_t [8] = '{16'h0031, 16'h0971, 16'h0211, 16'h0A70, 16'h0310, 16'h0BC1, 16'h02D1, 16'h0301};
  logic [15:0] sc_t  [4] = '{16'h0271, 16'h0070, 16'h0200, 16'h0371};
  // Cfg, loop reg, state, expected {line_b1, line_b2, bus_b1, bus_b2}
  logic [55:0] dt_t  [8] = '{{24'h020007, 32'h33441122}, {24'h020207, 32'h11441122},
                            {24'h020607, 32'h11221122}, {24'h020E07, 32'h22111122},
                            {24'h020807, 32'h33441122}, {24'h020E00, 32'h33441122},
                            {24'h023007, 32'h33443344}, {24'h003007, 32'h33441122}};

  lbm_loop_maint lbm_loop_maint_inst (.i_ref_clk, .i_reset_n, .i_mode_strap, .i_frame_sync, .i_ci_cmd,
    .i_l1_state, .i_l1_ind, .i_line_cv, .i_line_b1, .i_line_b2, .i_bus_b1, .i_bus_b2, .o_line_b1,
    .o_line_b2, .o_bus_b1, .o_bus_b2, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .o_analog_loop, .o_line_tx_mute, .o_ci_ind, .o_sm_reset, .o_force_idle, .o_ignore_rx,
    .o_clk_request, .o_mode);

  lbm_ctrl_model lbm_ctrl_model_inst (.i_next_cmd(next_cmd), .o_frame_sync(i_frame_sync), .o_ci_cmd(i_ci_cmd));

  // ==========================================================
  // Clock, timeout and reset-pulse catcher
  always #10 i_ref_clk = ~i_ref_clk;

  always @(posedge i_ref_clk) begin
    cycles++;
    seen_rst <= (o_sm_reset === 1'b1) || (seen_rst && i_reset_n);
    if (cycles == 20000) begin
      err_count++;
      $display("ERROR timeout expected done seen hang");
      complete_run();
    end
  end

  // ==========================================================
  // Tasks
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
  endtask

  // Read data stand one cycle only, then return to zero
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    #1 check("rdata", exp, o_reg_rdata);
    @(posedge i_ref_clk);
    #1 check("rdata_idle", 32'h0, o_reg_rdata);
  endtask

  // Settle point is seven reference cycles after a frame sync rise
  task automatic frames(input int n);
    repeat (n) @(posedge i_frame_sync);
    repeat (7) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    i_ref_clk = 1'b0; i_reset_n = 1'b0; i_mode_strap = 1'b0; i_line_cv = 1'b0;
    i_reg_wr = 1'b0; i_reg_rd = 1'b0; i_reg_addr = 4'h0; i_reg_wdata = 8'h00;
    i_l1_state = 4'h0; i_l1_ind = `LBM_CI_AI; next_cmd = `LBM_CI_TIM;
    i_line_b1 = 8'h11; i_line_b2 = 8'h22; i_bus_b1 = 8'h33; i_bus_b2 = 8'h44;
    err_count = 0; cmp_count = 0; cycles = 0;
    repeat (12) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    #1 check("mode", LBM_MODE_TE, o_mode);
    reg_rd(`LBM_OFS_CFG, `LBM_CFG_RST);
    reg_rd(`LBM_OFS_LOOP, `LBM_LP_RST);
    reg_wr(`LBM_OFS_LOOP, 8'h06);
    reg_rd(`LBM_OFS_LOOP, 8'h06);
    reg_wr(4'hF, 8'h3C);
    reg_rd(4'hF, 8'h00);
    reg_wr(`LBM_OFS_LOOP, 8'h00);
    // Analog loop command against mode and state
    for (k = 0; k < 8; k++) begin
      reg_wr(`LBM_OFS_CFG, arl_t[k][15:8]);
      i_l1_state <= arl_t[k][7:4];
      next_cmd <= `LBM_CI_ARL;
      frames(3);
      check("analog_loop", arl_t[k][0], o_analog_loop);
      check("tx_mute", arl_t[k][0] & ~arl_t[k][11], o_line_tx_mute);
      next_cmd <= `LBM_CI_TIM;
      frames(2);
      check("loop_open", 32'h0, o_analog_loop);
    end
    // Complete-loop bit against mode and state
    reg_wr(`LBM_OFS_LOOP, 8'h01);
    for (k = 0; k < 4; k++) begin
      reg_wr(`LBM_OFS_CFG, sc_t[k][15:8]);
      i_l1_state <= sc_t[k][7:4];
      frames(2);
      check("sc_loop", sc_t[k][0], o_analog_loop);
    end
    // Single-channel loops on the B data paths
    for (k = 0; k < 8; k++) begin
      reg_wr(`LBM_OFS_CFG, dt_t[k][55:48]);
      reg_wr(`LBM_OFS_LOOP, dt_t[k][47:40]);
      i_l1_state <= dt_t[k][35:32];
      repeat (3) @(posedge i_ref_clk);
      #1 check("b_data", dt_t[k][31:0], {o_line_b1, o_line_b2, o_bus_b1, o_bus_b2});
    end
    reg_wr(`LBM_OFS_LOOP, 8'h00);
    // Code violation shown for six frames, then nothing when disabled
    reg_wr(`LBM_OFS_CFG, 8'h06);
    i_l1_state <= `LBM_ST_ACTIVATED;
    frames(2);
    @(negedge i_frame_sync);
    @(posedge i_ref_clk);
    i_line_cv <= 1'b1;
    @(posedge i_ref_clk);
    i_line_cv <= 1'b0;
    for (k = 0; k < 7; k++) begin
      frames(1);
      check("ci_ind", (k < 6) ? `LBM_CI_CVR : `LBM_CI_AI, o_ci_ind);
    end
    // Violation one cycle before a frame boundary is shown at that boundary
    @(posedge i_frame_sync);
    @(posedge i_ref_clk);
    i_line_cv <= 1'b1;
    @(posedge i_ref_clk);
    i_line_cv <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1 check("ci_ind_fast", `LBM_CI_CVR, o_ci_ind);
    reg_wr(`LBM_OFS_CFG, 8'h02);
    @(negedge i_frame_sync);
    @(posedge i_ref_clk);
    i_line_cv <= 1'b1;
    @(posedge i_ref_clk);
    i_line_cv <= 1'b0;
    frames(1);
    check("ci_ind_off", `LBM_CI_AI, o_ci_ind);
    // Strap start-up and the LT-T entry order
    @(posedge i_ref_clk);
    i_reset_n <= 1'b0;
    i_mode_strap <= 1'b1;
    next_cmd <= `LBM_CI_RES;
    frames(2);
    @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    frames(2);
    check("strap_mode", LBM_MODE_LTS, o_mode);
    check("sm_reset", 32'h1, seen_rst);
    check("force_idle", 32'h1, o_force_idle);
    check("ignore_rx", 32'h1, o_ignore_rx);
    reg_wr(`LBM_OFS_CFG, 8'h01);
    repeat (2) @(posedge i_ref_clk);
    #1 check("ltt_mode", LBM_MODE_LTT, o_mode);
    next_cmd <= `LBM_CI_TIM;
    frames(2);
    check("clk_request", 32'h1, o_clk_request);
    check("force_idle_off", 32'h0, o_force_idle);
    reg_rd(`LBM_OFS_STAT, 8'h10);
    complete_run();
  end
endmodule
